// >>> logic/flash_id_power_suspend_cmds.sv
// Purpose: decode of release/id, id reads, high-performance mode,
//          continuous-read exit and program/erase suspend/resume
// Assumes: spi mode 0 or 3; engine signals on the core clock
// Notes:   frame fields cross as held words, qualified by a toggle
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_params.svh"
module flash_id_power_suspend_cmds #(
	parameter logic [7:0] MAKER_ID  = 8'h5a, // arbitrary value
	parameter logic [7:0] MEM_TYPE  = 8'h40, // arbitrary value
	parameter logic [7:0] CAPACITY  = 8'h13, // arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h12  // arbitrary value
) (
	// core clock and reset
	input  wire logic       REF_CLK_I,
	input  wire logic       RST_I,
	// serial link
	input  wire logic       SCLK_I,
	input  wire logic       CS_N_I,
	input  wire logic       SI_I,
	output logic            SO_O,
	output logic            SO_OE_N_O,
	// program/erase engine
	input  wire logic       ENGINE_BUSY_I,
	input  wire logic       ENGINE_SUSPENDABLE_I,
	output logic            ENGINE_PAUSE_O,
	// continuous read mode byte from the read path
	input  wire logic       CONT_MODE_VALID_I,
	input  wire logic [7:0] CONT_MODE_BYTE_I,
	output logic            CONT_READ_O,
	// status
	output logic            WIP_O,
	output logic            SUS_O,
	output logic            DPD_O,
	output logic            HPM_O,
	// other commands handed on
	output logic            FWD_VALID_O,
	output logic [7:0]      FWD_OPCODE_O,
	output logic [3:0]      FWD_BYTES_O
);
	localparam int RES_WAIT = `RESUME_CYC;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic refused_in_suspend(input logic [7:0] op);
		refused_in_suspend = (op == `OP_WRSR) || (op == `OP_SE) ||
			(op == `OP_BE32) || (op == `OP_BE64) ||
			(op == `OP_CE_A) || (op == `OP_CE_B) ||
			(op == `OP_PP) || (op == `OP_QPP) ||
			(op == `OP_SR_ERASE) || (op == `OP_SR_PROG);
	endfunction

	function automatic logic handled_here(input logic [7:0] op);
		handled_here = (op == `OP_RELEASE) || (op == `OP_MAKER_ID) ||
			(op == `OP_FULL_ID) || (op == `OP_HPM) ||
			(op == `OP_CR_EXIT) || (op == `OP_SUSPEND) ||
			(op == `OP_RESUME) || (op == `OP_DPD);
	endfunction

	// ------------------------------------------------------------
	// link side: rising-edge input shifter
	// ------------------------------------------------------------
	// cs is an async reset here; the link clock stops between frames
	wire logic frame_rst = CS_N_I | RST_I;

	logic [2:0]             bit_cnt_ff;
	logic                   started_ff;
	logic [1:0]             sel_ff;
	logic [7:0]             shift_ff;
	logic                   frame_tgl_ff;
	flash_cmd_pkg::frame_s  frm_ff;
	flash_cmd_pkg::flags_s  flags_core;
	flash_cmd_pkg::flags_s  flags_l;

	wire logic [7:0] rx_byte = {shift_ff[6:0], SI_I};
	wire logic       byte_end = started_ff && (bit_cnt_ff == `BIT_LAST);
	wire logic [3:0] out_start = (frm_ff.opcode == `OP_FULL_ID) ?
		`NB_OPCODE : `NB_ARGS;
	wire logic is_id_op = (frm_ff.opcode == `OP_RELEASE) ||
		(frm_ff.opcode == `OP_MAKER_ID) ||
		(frm_ff.opcode == `OP_FULL_ID);
	wire logic id_allowed = !flags_l.write_in_progress_flag && !flags_l.cont_rd &&
		(!flags_l.dpd || frm_ff.opcode == `OP_RELEASE);
	wire logic data_ph = started_ff && is_id_op && id_allowed &&
		(frm_ff.bytes >= out_start);
	wire logic sel_wrap = (frm_ff.opcode == `OP_FULL_ID) &&
		(sel_ff == `SEL_IDENT_LAST);
	wire logic [1:0] nxt_sel = (data_ph && byte_end) ?
		(sel_wrap ? 2'h0 : sel_ff + 2'h1) : sel_ff;
	wire logic [3:0] nxt_bytes = !started_ff ? 4'h0 :
		(byte_end && frm_ff.bytes != `NB_MAX) ?
		frm_ff.bytes + 4'h1 : frm_ff.bytes;

	logic [7:0] tx_byte;
	always_comb begin
		tx_byte = DEVICE_ID;
		if (frm_ff.opcode == `OP_MAKER_ID) begin
			tx_byte = (sel_ff[0] ^ frm_ff.addr_lsb) ? DEVICE_ID : MAKER_ID;
		end else if (frm_ff.opcode == `OP_FULL_ID) begin
			unique case (sel_ff)
				2'h0: tx_byte = MAKER_ID;
				2'h1: tx_byte = MEM_TYPE;
				default: tx_byte = CAPACITY;
			endcase
		end
	end

	always_ff @(posedge SCLK_I or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt_ff <= 3'h0;
			started_ff <= 1'b0;
			sel_ff     <= 2'h0;
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			started_ff <= 1'b1;
			sel_ff     <= nxt_sel;
		end
	end

	// these survive chip select so the core can read them afterwards
	always_ff @(posedge SCLK_I or posedge RST_I) begin
		if (RST_I) begin
			shift_ff     <= 8'h00;
			frm_ff       <= '0;
			frame_tgl_ff <= 1'b0;
		end else begin
			shift_ff       <= rx_byte;
			frm_ff.bytes   <= nxt_bytes;
			frm_ff.aligned <= started_ff && (bit_cnt_ff == `BIT_LAST);
			if (!started_ff) begin
				frame_tgl_ff <= ~frame_tgl_ff;
			end
			if (byte_end && frm_ff.bytes == 4'h0) begin
				frm_ff.opcode <= rx_byte;
			end
			if (byte_end && frm_ff.bytes == `NB_ARGS - 4'h1) begin
				frm_ff.addr_lsb <= SI_I;
			end
		end
	end

	level_sync #(.W(3)) u_flags_sync (
		.clk_i (SCLK_I),
		.rst_i (RST_I),
		.d_i   (flags_core),
		.q_o   (flags_l)
	);

	id_serializer u_ser (
		.sclk_i      (SCLK_I),
		.frame_rst_i (frame_rst),
		.active_i    (data_ph),
		.tx_byte_i   (tx_byte),
		.bit_idx_i   (bit_cnt_ff),
		.so_o        (SO_O),
		.so_oe_n_o   (SO_OE_N_O)
	);

	// ------------------------------------------------------------
	// core side: frame end detection
	// ------------------------------------------------------------
	logic [1:0] cs_tgl_s;
	logic       cs_prev_ff;
	logic       seen_tgl_ff;

	level_sync #(.W(2)) u_cs_sync (
		.clk_i (REF_CLK_I),
		.rst_i (RST_I),
		.d_i   ({CS_N_I, frame_tgl_ff}),
		.q_o   (cs_tgl_s)
	);

	wire logic cs_s = cs_tgl_s[1];
	wire logic done = cs_s && !cs_prev_ff && (cs_tgl_s[0] != seen_tgl_ff);

	// ------------------------------------------------------------
	// core side: command decode
	// ------------------------------------------------------------
	logic dpd_ff;
	logic hpm_ff;
	logic cont_ff;
	logic sus_ff;
	logic paused_ff;
	logic wip_ff;

	assign flags_core = '{write_in_progress_flag: wip_ff, dpd: dpd_ff, cont_rd: cont_ff};

	wire logic [7:0] op = frm_ff.opcode;
	wire logic [3:0] nb = frm_ff.bytes;
	wire logic ok = done && frm_ff.aligned;
	wire logic gate = !dpd_ff && !cont_ff;
	wire logic is_rel = (op == `OP_RELEASE) &&
		(nb == `NB_OPCODE || nb >= `NB_ARGS);
	wire logic rel_ok = ok && is_rel && !wip_ff && !cont_ff;
	wire logic dpd_ok = ok && gate && !wip_ff &&
		(op == `OP_DPD) && (nb == `NB_OPCODE);
	wire logic hpm_ok = ok && gate &&
		(op == `OP_HPM) && (nb == `NB_ARGS);
	wire logic crx_ok = ok && !dpd_ff &&
		(op == `OP_CR_EXIT) && (nb == `NB_OPCODE);
	wire logic sus_ok = ok && gate && (op == `OP_SUSPEND) &&
		(nb == `NB_OPCODE) && !sus_ff && wip_ff &&
		ENGINE_SUSPENDABLE_I;
	wire logic res_ok = ok && gate && (op == `OP_RESUME) &&
		(nb == `NB_OPCODE) && sus_ff && !wip_ff;
	wire logic fwd_ok = ok && gate && !handled_here(op) &&
		!(sus_ff && refused_in_suspend(op));
	wire logic cont_set = CONT_MODE_VALID_I &&
		(CONT_MODE_BYTE_I[7:4] == `CONT_TAG);

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cs_prev_ff  <= 1'b1;
			seen_tgl_ff <= 1'b0;
		end else begin
			cs_prev_ff <= cs_s;
			if (done) begin
				seen_tgl_ff <= cs_tgl_s[0];
			end
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			dpd_ff <= 1'b0;
			hpm_ff <= 1'b0;
		end else begin
			if (rel_ok) begin
				dpd_ff <= 1'b0;
				hpm_ff <= 1'b0;
			end else if (dpd_ok) begin
				dpd_ff <= 1'b1;
				hpm_ff <= 1'b0;
			end else if (hpm_ok) begin
				hpm_ff <= 1'b1;
			end
		end
	end

	// mode byte set beats the exit opcode landing in the same cycle
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cont_ff <= 1'b0;
		end else if (cont_set) begin
			cont_ff <= 1'b1;
		end else if (crx_ok || CONT_MODE_VALID_I) begin
			cont_ff <= 1'b0;
		end
	end

	// the engine stops on pause; wip follows one cycle later
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sus_ff    <= 1'b0;
			paused_ff <= 1'b0;
			wip_ff    <= 1'b0;
		end else begin
			if (sus_ok) begin
				sus_ff    <= 1'b1;
				paused_ff <= 1'b1;
			end else if (res_ok) begin
				sus_ff    <= 1'b0;
				paused_ff <= 1'b0;
			end
			wip_ff <= ENGINE_BUSY_I && !paused_ff;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			FWD_VALID_O  <= 1'b0;
			FWD_OPCODE_O <= 8'h00;
			FWD_BYTES_O  <= 4'h0;
		end else begin
			FWD_VALID_O <= fwd_ok;
			if (fwd_ok) begin
				FWD_OPCODE_O <= op;
				FWD_BYTES_O  <= nb;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			WIP_O          <= 1'b0;
			SUS_O          <= 1'b0;
			DPD_O          <= 1'b0;
			HPM_O          <= 1'b0;
			CONT_READ_O    <= 1'b0;
			ENGINE_PAUSE_O <= 1'b0;
		end else begin
			WIP_O          <= wip_ff;
			SUS_O          <= sus_ff;
			DPD_O          <= dpd_ff;
			HPM_O          <= hpm_ff;
			CONT_READ_O    <= cont_ff;
			ENGINE_PAUSE_O <= paused_ff;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_RELEASE: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		rel_ok |=> !dpd_ff && !hpm_ff)
		else $error("release did not clear power-down");
	AST_BUSY_IGNORE: assert property (@(posedge REF_CLK_I)
		disable iff (RST_I)
		ok && op == `OP_RELEASE && wip_ff |=> $stable(dpd_ff))
		else $error("release acted while busy");
	AST_HPM_ENTER: assert property (@(posedge REF_CLK_I)
		disable iff (RST_I)
		ok && gate && op == `OP_HPM && nb == `NB_ARGS |=> hpm_ff)
		else $error("high-performance mode not entered");
	AST_DPD_LEAVE_HPM: assert property (@(posedge REF_CLK_I)
		disable iff (RST_I) dpd_ok |=> dpd_ff && !hpm_ff)
		else $error("power-down kept high-performance mode");
	AST_CONT_HIDES: assert property (@(posedge REF_CLK_I)
		disable iff (RST_I) done && cont_ff |=> !FWD_VALID_O)
		else $error("command seen in continuous read");
	AST_SUS_IGNORE: assert property (@(posedge REF_CLK_I)
		disable iff (RST_I)
		ok && op == `OP_SUSPEND && (sus_ff || !wip_ff) |=>
		$stable(sus_ff))
		else $error("suspend taken when not allowed");
	AST_SUS_WIP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		sus_ok |=> sus_ff ##[1:2] !wip_ff)
		else $error("wip not cleared after suspend");
	AST_SUS_REFUSE: assert property (@(posedge REF_CLK_I)
		disable iff (RST_I)
		done && sus_ff && refused_in_suspend(op) |=> !FWD_VALID_O)
		else $error("write command passed while suspended");
	AST_RESUME: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
		res_ok && ENGINE_BUSY_I |=> !sus_ff ##[1:RES_WAIT] wip_ff)
		else $error("resume did not restart the cycle");
	AST_DPD_IGNORE: assert property (@(posedge REF_CLK_I)
		disable iff (RST_I) done && dpd_ff |=> !FWD_VALID_O)
		else $error("command taken in deep power-down");

	COV_RELEASE: cover property (@(posedge REF_CLK_I) rel_ok && dpd_ff);
	COV_SUSPEND: cover property (@(posedge REF_CLK_I) sus_ok);
	COV_RESUME: cover property (@(posedge REF_CLK_I) res_ok);
	COV_CONT_EXIT: cover property (@(posedge REF_CLK_I) crx_ok && cont_ff);
endmodule // flash_id_power_suspend_cmds
`default_nettype wire

// >>> logic/flash_cmd_params.svh
// Purpose: opcodes and timing figures of the id/power/suspend decoder
// Assumes: 100 MHz core clock
// Notes:   definitions only
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OP_RELEASE   8'hab
`define OP_MAKER_ID  8'h90
`define OP_FULL_ID   8'h9f
`define OP_HPM       8'ha3
`define OP_CR_EXIT   8'hff
`define OP_SUSPEND   8'h75
`define OP_RESUME    8'h7a
`define OP_DPD       8'hb9
`define OP_WRSR      8'h01
`define OP_SE        8'h20
`define OP_BE32      8'h52
`define OP_BE64      8'hd8
`define OP_CE_A      8'h60
`define OP_CE_B      8'hc7
`define OP_PP        8'h02
`define OP_QPP       8'h32
`define OP_SR_ERASE  8'h44
`define OP_SR_PROG   8'h42

// ----------------------------------------------------------------
// frame layout and timing
// ----------------------------------------------------------------
`define NB_OPCODE    4'h1
`define NB_ARGS      4'h4
`define NB_MAX       4'hf
`define BIT_LAST     3'h7
`define SEL_IDENT_LAST 2'h2
`define CONT_TAG     4'ha
`define CLK_NS       10
`define RESUME_NS    200
`define RESUME_CYC   (`RESUME_NS / `CLK_NS)

`endif

// >>> logic/flash_cmd_pkg.sv
// Purpose: shared types of the id/power/suspend decoder
// Assumes: nothing
// Notes:   no constants here, see flash_cmd_params.svh
`default_nettype none
package flash_cmd_pkg;

	// one received frame, held steady while chip select is high
	typedef struct packed {
		logic [7:0] opcode;
		logic [3:0] bytes;
		logic       aligned;
		logic       addr_lsb;
	} frame_s;

	// core state that the link side must see
	typedef struct packed {
		logic write_in_progress_flag;
		logic dpd;
		logic cont_rd;
	} flags_s;

	typedef enum logic [1:0] {
		ID_IDLE,
		ID_SEND,
		ID_BLOCKED
	} id_state_e;

endpackage
`default_nettype wire

// >>> logic/level_sync.sv
// Purpose: two-flop synchroniser for quasi-static levels
// Assumes: source changes slowly relative to the clock
// Notes:   first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			q_o     <= '0;
		end else begin
			meta_ff <= d_i;
			q_o     <= meta_ff;
		end
	end
endmodule // level_sync
`default_nettype wire

// >>> logic/id_serializer.sv
// Purpose: drives the serial output on falling link clock edges
// Assumes: bit_idx counts rising edges within the current byte
// Notes:   released the moment chip select rises
`timescale 1ns/1ps
`default_nettype none
module id_serializer (
	// link clock and frame reset
	input  wire logic       sclk_i,
	input  wire logic       frame_rst_i,
	// data to send
	input  wire logic       active_i,
	input  wire logic [7:0] tx_byte_i,
	input  wire logic [2:0] bit_idx_i,
	// pin
	output logic            so_o,
	output logic            so_oe_n_o
);
	wire logic [2:0] pos = ~bit_idx_i;
	wire logic       nxt_so = tx_byte_i[pos];

	// msb first: bit 7 leaves on the fall after the last argument bit, or after the last opcode bit for the full id
	always_ff @(negedge sclk_i or posedge frame_rst_i) begin
		if (frame_rst_i) begin
			so_o      <= 1'b0;
			so_oe_n_o <= 1'b1;
		end else begin
			so_o      <= nxt_so;
			so_oe_n_o <= ~active_i;
		end
	end

	AST_HIZ_IDLE: assert property (@(negedge sclk_i)
		disable iff (frame_rst_i) !active_i |=> so_oe_n_o)
		else $error("output driven outside the id phase");
endmodule // id_serializer
`default_nettype wire

// >>> tb/spi_host_model.sv
// Purpose: host side of the serial link, one frame per task call
// Assumes: mode 0, link clock idle low between frames
// Notes:   released bits read back as unknown, never as stale data
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
	parameter int HALF_NS = 3,
	parameter int GAP_NS  = 60
) (
	// link pins
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      si_o,
	input  wire logic so_i,
	input  wire logic so_oe_n_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o   = 1'b0;
	end

	// ------------------------------------------------------------
	// frame: ntx bytes from the top of tx, then nrx bits back
	// ------------------------------------------------------------
	task automatic frame(input logic [31:0] tx, input int ntx,
		input int nrx, output logic [31:0] rx);
		rx = 32'h0;
		cs_n_o = 1'b0;
		for (int i = 0; i < 8 * ntx + nrx; i++) begin
			// filler toggles so a stale level is never mistaken
			si_o = (i < 8 * ntx) ? tx[31 - i] : ~si_o;
			#HALF_NS sclk_o = 1'b1;
			if (i >= 8 * ntx)
				rx = {rx[30:0], so_oe_n_i ? 1'bx : so_i};
			#HALF_NS sclk_o = 1'b0;
		end
		#HALF_NS cs_n_o = 1'b1;
		si_o = ~si_o;
		// recovery kept after every frame, simplest safe choice
		#GAP_NS;
	endtask
endmodule // spi_host_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench of the id/power/suspend decoder
// Assumes: host model drives the link, bench the engine side
// Notes:   link clock 6 ns against a 10 ns core clock
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_params.svh"
module tb;
	// arbitrary id values
	localparam logic [7:0] MK = 8'h3c;
	localparam logic [7:0] MT = 8'h61;
	localparam logic [7:0] CP = 8'h0e;
	localparam logic [7:0] DV = 8'hc5;

	logic        clk, rst, sclk, cs_n, si, so, so_oe_n;
	logic        busy, susp_ok, cm_vld, pause, cont;
	logic        write_in_progress_flag, suspended_flag, dpd, high_perf_mode, fwd_vld;
	logic [7:0]  cm_byte, fwd_op;
	logic [3:0]  fwd_nb;
	logic [31:0] rx;
	int          num_errors = 0;
	int          n_checks = 0;
	int          cycles = 0;
	int          fwd_cnt = 0;

	flash_id_power_suspend_cmds #(.MAKER_ID(MK), .MEM_TYPE(MT),
		.CAPACITY(CP), .DEVICE_ID(DV)) dut (
		.REF_CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
		.SI_I(si), .SO_O(so), .SO_OE_N_O(so_oe_n),
		.ENGINE_BUSY_I(busy), .ENGINE_SUSPENDABLE_I(susp_ok),
		.ENGINE_PAUSE_O(pause), .CONT_MODE_VALID_I(cm_vld),
		.CONT_MODE_BYTE_I(cm_byte), .CONT_READ_O(cont), .WIP_O(write_in_progress_flag),
		.SUS_O(suspended_flag), .DPD_O(dpd), .HPM_O(high_perf_mode), .FWD_VALID_O(fwd_vld),
		.FWD_OPCODE_O(fwd_op), .FWD_BYTES_O(fwd_nb));

	spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
		.so_i(so), .so_oe_n_i(so_oe_n));

	always #5 clk = ~clk;

	// ------------------------------------------------------------
	// watchdog and forward pulse count
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (fwd_vld === 1'b1)
			fwd_cnt <= fwd_cnt + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// frame off both clocks' edges, then let the flags settle
	task automatic send(input logic [7:0] op, input logic [23:0] arg,
		input int ntx, input int nrx);
		@(negedge clk);
		#1.7;
		host.frame({op, arg}, ntx, nrx, rx);
		repeat (8) @(negedge clk);
	endtask

	function automatic logic [31:0] stat();
		return {24'h0, so_oe_n, write_in_progress_flag, suspended_flag, dpd, high_perf_mode, cont, pause, fwd_vld};
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_ids();
		send(`OP_FULL_ID, 24'h0, 1, 32);
		chk_word("full id", {MK, MT, CP, MK}, rx);
		chk_word("oe idle", 32'h80, stat());
		send(`OP_MAKER_ID, 24'h000000, 4, 32);
		chk_word("ids addr 0", {MK, DV, MK, DV}, rx);
		send(`OP_MAKER_ID, 24'h000001, 4, 32);
		chk_word("ids addr 1", {DV, MK, DV, MK}, rx);
		send(`OP_RELEASE, 24'h0, 4, 24);
		chk_word("release id", {8'h0, DV, DV, DV}, rx);
	endtask

	task automatic t_power();
		int n0;
		n0 = fwd_cnt;
		send(`OP_DPD, 24'h0, 1, 0);
		chk_word("dpd on", 32'h1, dpd);
		// no identification read is sent while powered down
		send(`OP_HPM, 24'h0, 4, 0);
		send(`OP_SE, 24'h0, 4, 0);
		chk_word("dpd hides", {n0[30:0], 1'b0}, {fwd_cnt[30:0], high_perf_mode});
		send(`OP_RELEASE, 24'h0, 1, 0);
		chk_word("dpd off", 32'h0, dpd);
		send(`OP_HPM, 24'h0, 3, 0);
		chk_word("hpm short", 32'h0, high_perf_mode);
		send(`OP_HPM, 24'h0, 4, 0);
		chk_word("hpm on", 32'h1, high_perf_mode);
		send(`OP_RELEASE, 24'h0, 1, 0);
		chk_word("hpm off rel", 32'h0, high_perf_mode);
		send(`OP_HPM, 24'h0, 4, 0);
		send(`OP_DPD, 24'h0, 1, 0);
		chk_word("hpm off dpd", 32'h1, {high_perf_mode, dpd});
		send(`OP_RELEASE, 24'h0, 1, 0);
	endtask

	task automatic t_cont();
		@(negedge clk);
		cm_vld = 1'b1;
		cm_byte = 8'ha5;
		@(negedge clk);
		cm_vld = 1'b0;
		// status output trails the mode flag by one cycle
		@(negedge clk);
		chk_word("cont on", 32'h1, cont);
		send(`OP_FULL_ID, 24'h0, 1, 32);
		chk_word("cont id", 32'hxxxxxxxx, rx);
		send(`OP_DPD, 24'h0, 1, 0);
		chk_word("cont dpd", 32'h1, {dpd, cont});
		send(`OP_CR_EXIT, 24'h0, 1, 0);
		chk_word("cont off", 32'h0, cont);
	endtask

	task automatic t_suspend();
		logic [7:0] blk[10] = '{`OP_WRSR, `OP_SE, `OP_BE32, `OP_BE64,
			`OP_CE_A, `OP_CE_B, `OP_PP, `OP_QPP, `OP_SR_ERASE,
			`OP_SR_PROG};
		int n0;
		@(negedge clk);
		busy = 1'b1;
		repeat (6) @(negedge clk);
		send(`OP_SUSPEND, 24'h0, 1, 0);
		chk_word("sus unsuspendable", 32'hc0, stat());
		susp_ok = 1'b1;
		send(`OP_RELEASE, 24'h0, 4, 24);
		chk_word("id in wip", {8'h0, 24'hxxxxxx}, rx);
		send(`OP_FULL_ID, 24'h0, 1, 32);
		chk_word("full_identification_cmd in wip", 32'hxxxxxxxx, rx);
		send(`OP_RESUME, 24'h0, 1, 0);
		chk_word("resume early", 32'hc0, stat());
		send(`OP_SUSPEND, 24'h0, 1, 0);
		chk_word("suspended", 32'ha2, stat());
		n0 = fwd_cnt;
		foreach (blk[i])
			send(blk[i], 24'h0, 1, 0);
		chk_word("refused fwd", n0, fwd_cnt);
		send(`OP_SUSPEND, 24'h0, 1, 0);
		chk_word("second sus", 32'ha2, stat());
		send(`OP_RESUME, 24'h0, 1, 0);
		chk_word("resumed", 32'hc0, stat());
		send(`OP_SE, 24'h0, 4, 0);
		chk_word("fwd se", {n0[19:0] + 20'h1, `OP_SE, 4'h4},
			{fwd_cnt[19:0], fwd_op, fwd_nb});
		send(`OP_SUSPEND, 24'h0, 1, 0);
		@(negedge clk);
		rst = 1'b1;
		busy = 1'b0;
		@(negedge clk);
		chk_word("reset in sus", 32'h80, stat());
		rst = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		busy = 1'b0;
		susp_ok = 1'b0;
		cm_vld = 1'b0;
		cm_byte = 8'h00;
		repeat (8) @(negedge clk);
		chk_word("reset state", 32'h80, stat());
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_ids();
		t_power();
		t_cont();
		t_suspend();
		t_ids();
		final_report();
	end
endmodule // tb
`default_nettype wire
